// ### sgmii_link_model.sv
// Model of the serial transceiver side: idles between frames, frames on request.
// Assumes the constants header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "sgmii_rx_elastic_buffer_cfg.svh"
module sgmii_link_model (
	// Recovered clock.
	input wire logic rec_clk,
	// Frame request.
	input wire logic go,
	input wire logic [15:0] len,
	input wire logic [7:0] rep,
	output logic busy,
	// Received code groups.
	output logic [7:0] data,
	output logic is_k,
	output logic err
);
	logic [15:0] sent_ff;
	logic comma_ff;
	logic alt_ff;
	initial begin
		busy = 1'b0;
		sent_ff = 16'h0000;
		comma_ff = 1'b0;
		alt_ff = 1'b0;
	end
	// Words change only on the recovered clock.
	// Serial mode only, so no delay calibration reference clock is supplied.
	always @(posedge rec_clk) begin
		err <= 1'b0;
		if (busy) begin
			data <= 8'(sent_ff / rep);
			is_k <= 1'b0;
			sent_ff <= sent_ff + 16'h0001;
			if (sent_ff == len - 16'h0001)
				busy <= 1'b0;
		end else if (go && !comma_ff) begin
			data <= 8'h00;
			is_k <= 1'b0;
			sent_ff <= 16'h0001;
			busy <= 1'b1;
		end else begin
			// Idle pairs, both data codes in turn.
			comma_ff <= !comma_ff;
			is_k <= !comma_ff;
			data <= !comma_ff ? `EB_COMMA : (alt_ff ? `EB_IDLE2_D : `EB_IDLE1_D);
			if (comma_ff)
				alt_ff <= !alt_ff;
		end
	end
endmodule : sgmii_link_model
`default_nettype wire

// ### sgmii_rx_elastic_buffer.sv
// Receive elastic buffer between the serial transceiver and the MAC receive path.
// Assumes REC_CLK is the free-running recovered clock and REF_CLK the local core clock.
`timescale 1ns/1ns
`default_nettype none
`include "sgmii_rx_elastic_buffer_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Small output FIFO with valid and ready on both sides.
module eb_out_fifo #(
	parameter int W = 10,
	parameter int DEPTH = `EB_OUT_DEPTH
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = DEPTH[AW:0];
	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = cnt_ff != FULL;
	assign out_valid = cnt_ff != '0;
	assign out_data = mem_ff[rp_ff];
	always_ff @(posedge clk) begin
		if (push)
			mem_ff[wp_ff] <= in_data;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff <= wp_ff + AW'(push);
			rp_ff <= rp_ff + AW'(pop);
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : eb_out_fifo

////////////////////////////////////////////////////////////////////////////////
// Elastic buffer top.
module sgmii_rx_elastic_buffer #(
	parameter int ADDR_W = `EB_ADDR_W,
	parameter bit USE_FABRIC = `EB_USE_FABRIC
) (
	// Local clock and reset.
	input wire logic REF_CLK,
	input wire logic RST,
	// Recovered clock side from the transceiver.
	input wire logic REC_CLK,
	input wire logic [7:0] LINK_DATA,
	input wire logic LINK_IS_K,
	input wire logic LINK_ERR,
	// Transceiver data through its own buffer, local clock.
	input wire logic [7:0] LOCAL_DATA,
	input wire logic LOCAL_IS_K,
	input wire logic LOCAL_ERR,
	// Transceiver buffer control.
	output logic XCVR_BUF_BYPASS,
	// Stream to the MAC.
	output logic [7:0] OUT_DATA,
	output logic OUT_IS_K,
	output logic OUT_ERR,
	output logic OUT_VALID,
	input wire logic OUT_READY,
	// Error events.
	output logic BUF_OVERFLOW,
	output logic BUF_UNDERFLOW
);
	import sgmii_rx_elastic_buffer_pkg::*;

	localparam int DEPTH_N = 1 << ADDR_W;
	localparam logic [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
	localparam logic [ADDR_W:0] HALF = {2'b01, {(ADDR_W-1){1'b0}}};
	localparam eb_word_t COMMA_W = {2'b01, `EB_COMMA};

	function automatic logic [ADDR_W:0] to_gray(input logic [ADDR_W:0] b);
		to_gray = b ^ (b >> 1);
	endfunction : to_gray

	function automatic logic [ADDR_W:0] from_gray(input logic [ADDR_W:0] g);
		logic [ADDR_W:0] b;
		b = '0;
		b[ADDR_W] = g[ADDR_W];
		for (int i = ADDR_W - 1; i >= 0; i--)
			b[i] = g[i] ^ b[i+1];
		from_gray = b;
	endfunction : from_gray

	eb_word_t mem_ff [DEPTH_N];

	assign XCVR_BUF_BYPASS = USE_FABRIC;

	////////////////////////////////////////////////////////////////////////////
	// Recovered clock domain: reset sync, idle deletion, write pointer.
	logic [ADDR_W:0] rd_ptr_ff;
	logic [ADDR_W:0] rd_gray_ff;
	logic [2:0] wrst_sync_ff;
	logic wrst_ff;
	logic [ADDR_W:0] wr_ptr_ff;
	logic [ADDR_W:0] wr_gray_ff;
	logic [ADDR_W:0] rgray_s1_ff;
	logic [ADDR_W:0] rgray_s2_ff;
	logic [ADDR_W:0] rgray_s3_ff;
	logic [ADDR_W:0] rgray_w_ff;
	eb_word_t hold_ff;
	logic hold_vld_ff;
	logic ovf_tog_ff;

	wire eb_word_t in_word = {LINK_ERR, LINK_IS_K, LINK_DATA};
	wire [ADDR_W:0] wr_occ = wr_ptr_ff - from_gray(rgray_w_ff);
	wire hold_comma = hold_vld_ff && (hold_ff == COMMA_W);
	wire in_idle_d = !LINK_IS_K && (LINK_DATA == `EB_IDLE1_D || LINK_DATA == `EB_IDLE2_D);
	wire del_pair = hold_comma && in_idle_d && (wr_occ > HALF);
	wire wr_full = wr_occ == DEPTH;
	wire wr_en = hold_vld_ff && !del_pair && !wr_full;
	wire wr_ovf = hold_vld_ff && !del_pair && wr_full;

	always_ff @(posedge REC_CLK) begin
		wrst_sync_ff <= {wrst_sync_ff[1:0], RST};
		if (wrst_sync_ff[1] == wrst_sync_ff[2])
			wrst_ff <= wrst_sync_ff[2];
	end

	always_ff @(posedge REC_CLK) begin
		rgray_s1_ff <= rd_gray_ff;
		rgray_s2_ff <= rgray_s1_ff;
		rgray_s3_ff <= rgray_s2_ff;
	end

	always_ff @(posedge REC_CLK) begin
		if (wr_en)
			mem_ff[wr_ptr_ff[ADDR_W-1:0]] <= hold_ff;
	end

	always_ff @(posedge REC_CLK) begin
		if (wrst_ff) begin
			wr_ptr_ff <= '0;
			wr_gray_ff <= '0;
			rgray_w_ff <= '0;
			hold_ff <= '0;
			hold_vld_ff <= 1'b0;
			ovf_tog_ff <= 1'b0;
		end else begin
			// Gray values are taken as they arrive; an agreement wait starves a pointer moving every cycle.
			rgray_w_ff <= rgray_s3_ff;
			hold_ff <= in_word;
			hold_vld_ff <= !del_pair;
			wr_ptr_ff <= wr_ptr_ff + (ADDR_W+1)'(wr_en);
			wr_gray_ff <= to_gray(wr_ptr_ff + (ADDR_W+1)'(wr_en));
			ovf_tog_ff <= ovf_tog_ff ^ wr_ovf;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Local clock domain: pointer sync, start at half, idle insertion.
	logic [ADDR_W:0] wgray_s1_ff;
	logic [ADDR_W:0] wgray_s2_ff;
	logic [ADDR_W:0] wgray_s3_ff;
	logic [ADDR_W:0] wgray_r_ff;
	logic [2:0] ovf_s_ff;
	logic ovf_seen_ff;
	logic started_ff;
	logic prev_comma_ff;
	eb_word_t last_d_ff;
	rd_state_t state_ff;
	rd_state_t nxt_state;
	logic ovf_out_ff;
	logic udf_out_ff;

	wire [ADDR_W:0] rd_occ = from_gray(wgray_r_ff) - rd_ptr_ff;
	wire rd_empty = rd_occ == '0;
	wire eb_word_t rd_word = mem_ff[rd_ptr_ff[ADDR_W-1:0]];
	wire rd_idle_d = !rd_word[8] && (rd_word[7:0] == `EB_IDLE1_D || rd_word[7:0] == `EB_IDLE2_D);
	wire fifo_ready;
	wire fab_valid = (state_ff != RD_NORMAL) || (started_ff && !rd_empty);
	wire eb_word_t fab_word = (state_ff == RD_INS_K) ? COMMA_W : (state_ff == RD_INS_D) ? last_d_ff : rd_word;
	wire fab_push = fab_valid && fifo_ready;
	wire rd_adv = fab_push && (state_ff == RD_NORMAL);
	wire rd_udf = started_ff && (state_ff == RD_NORMAL) && rd_empty && fifo_ready;
	wire ins_req = rd_adv && rd_idle_d && prev_comma_ff && (rd_occ <= HALF);
	wire ovf_evt = (ovf_s_ff[1] == ovf_s_ff[2]) && (ovf_s_ff[2] != ovf_seen_ff);
	wire eb_word_t local_word = {LOCAL_ERR, LOCAL_IS_K, LOCAL_DATA};
	wire fifo_valid = USE_FABRIC ? fab_valid : 1'b1;
	wire eb_word_t fifo_word = USE_FABRIC ? fab_word : local_word;
	wire local_drop = !USE_FABRIC && !fifo_ready;
	wire eb_word_t out_word;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RD_NORMAL: begin
				if (ins_req)
					nxt_state = RD_INS_K;
			end
			RD_INS_K: begin
				if (fifo_ready)
					nxt_state = RD_INS_D;
			end
			RD_INS_D: begin
				if (fifo_ready)
					nxt_state = RD_NORMAL;
			end
			default: nxt_state = RD_NORMAL;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		wgray_s1_ff <= wr_gray_ff;
		wgray_s2_ff <= wgray_s1_ff;
		wgray_s3_ff <= wgray_s2_ff;
		ovf_s_ff <= {ovf_s_ff[1:0], ovf_tog_ff};
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wgray_r_ff <= '0;
			rd_ptr_ff <= '0;
			rd_gray_ff <= '0;
			ovf_seen_ff <= 1'b0;
			started_ff <= 1'b0;
			prev_comma_ff <= 1'b0;
			last_d_ff <= '0;
			state_ff <= RD_NORMAL;
			ovf_out_ff <= 1'b0;
			udf_out_ff <= 1'b0;
		end else begin
			wgray_r_ff <= wgray_s3_ff;
			if (ovf_s_ff[1] == ovf_s_ff[2])
				ovf_seen_ff <= ovf_s_ff[2];
			started_ff <= rd_udf ? 1'b0 : (started_ff || rd_occ >= HALF);
			rd_ptr_ff <= rd_ptr_ff + (ADDR_W+1)'(rd_adv);
			rd_gray_ff <= to_gray(rd_ptr_ff + (ADDR_W+1)'(rd_adv));
			if (fab_push)
				prev_comma_ff <= fab_word == COMMA_W;
			if (ins_req)
				last_d_ff <= rd_word;
			state_ff <= nxt_state;
			ovf_out_ff <= USE_FABRIC ? ovf_evt : local_drop;
			udf_out_ff <= USE_FABRIC && rd_udf;
		end
	end

	eb_out_fifo #(.W(10), .DEPTH(`EB_OUT_DEPTH)) u_out_fifo (
		.clk(REF_CLK),
		.rst(RST),
		.in_valid(fifo_valid),
		.in_ready(fifo_ready),
		.in_data(fifo_word),
		.out_valid(OUT_VALID),
		.out_ready(OUT_READY),
		.out_data(out_word)
	);

	assign OUT_ERR = out_word[9];
	assign OUT_IS_K = out_word[8];
	assign OUT_DATA = out_word[7:0];
	assign BUF_OVERFLOW = ovf_out_ff;
	assign BUF_UNDERFLOW = udf_out_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_wr_occ_bound;
		@(posedge REC_CLK) disable iff (RST || wrst_ff) wr_occ <= DEPTH;
	endproperty
	a_wr_occ_bound: assert property (p_wr_occ_bound) else $error("write occupancy above depth");

	property p_rd_occ_bound;
		@(posedge REF_CLK) disable iff (RST) rd_occ <= DEPTH;
	endproperty
	a_rd_occ_bound: assert property (p_rd_occ_bound) else $error("read occupancy above depth");

	property p_del_only_above_half;
		@(posedge REC_CLK) disable iff (RST || wrst_ff) del_pair |-> hold_comma && wr_occ > HALF ##1 !hold_vld_ff;
	endproperty
	a_del_only_above_half: assert property (p_del_only_above_half) else $error("idle deleted at or below half");

	property p_start_at_half;
		@(posedge REF_CLK) disable iff (RST) $rose(started_ff) |-> $past(rd_occ) >= HALF;
	endproperty
	a_start_at_half: assert property (p_start_at_half) else $error("reading began below half full");

	property p_no_read_empty;
		@(posedge REF_CLK) disable iff (RST) rd_adv |-> !rd_empty ##1 rd_ptr_ff == $past(rd_ptr_ff) + 1'b1;
	endproperty
	a_no_read_empty: assert property (p_no_read_empty) else $error("read from empty buffer");

	property p_insert_pair;
		@(posedge REF_CLK) disable iff (RST) ins_req |=> state_ff == RD_INS_K;
	endproperty
	a_insert_pair: assert property (p_insert_pair) else $error("inserted idle pair incomplete");

	property p_insert_data;
		@(posedge REF_CLK) disable iff (RST) state_ff == RD_INS_K && fifo_ready |=> state_ff == RD_INS_D;
	endproperty
	a_insert_data: assert property (p_insert_data) else $error("inserted idle data word missing");

	property p_ovf_toggle;
		@(posedge REC_CLK) disable iff (RST || wrst_ff) wr_ovf |=> ovf_tog_ff != $past(ovf_tog_ff);
	endproperty
	a_ovf_toggle: assert property (p_ovf_toggle) else $error("overflow not signalled");

	property p_ovf_reaches_out;
		@(posedge REF_CLK) disable iff (RST) USE_FABRIC && ovf_evt |=> BUF_OVERFLOW;
	endproperty
	a_ovf_reaches_out: assert property (p_ovf_reaches_out) else $error("overflow pulse missing");

	property p_ovf_quiet;
		@(posedge REF_CLK) disable iff (RST) USE_FABRIC && !ovf_evt |=> !BUF_OVERFLOW;
	endproperty
	a_ovf_quiet: assert property (p_ovf_quiet) else $error("overflow flagged without an event");

	property p_udf_out;
		@(posedge REF_CLK) disable iff (RST) USE_FABRIC && rd_udf |=> BUF_UNDERFLOW && !started_ff;
	endproperty
	a_udf_out: assert property (p_udf_out) else $error("underflow not flagged");

	property p_bypass;
		@(posedge REF_CLK) disable iff (RST) !USE_FABRIC && fifo_ready |=> OUT_VALID;
	endproperty
	a_bypass: assert property (p_bypass) else $error("transceiver path word lost");
endmodule : sgmii_rx_elastic_buffer
`default_nettype wire

// ### sgmii_rx_elastic_buffer_cfg.svh
// Constants of the receive elastic buffer: pointer size, code groups, rate figures.
// Assumes inclusion by the elastic buffer package and the buffer design file.
`ifndef SGMII_RX_ELASTIC_BUFFER_CFG_SVH
`define SGMII_RX_ELASTIC_BUFFER_CFG_SVH

`define EB_ADDR_W 7
`define EB_USE_FABRIC 1'b1
`define EB_COMMA 8'hbc
`define EB_IDLE1_D 8'hc5
`define EB_IDLE2_D 8'h50
`define EB_REPEAT_100M 10
`define EB_REPEAT_10M 100
`define EB_JUMBO_1G 280000
`define EB_JUMBO_100M 28000
`define EB_JUMBO_10M 2800
`define EB_OUT_DEPTH 4

`endif

// ### sgmii_rx_elastic_buffer_pkg.sv
// Types of the receive elastic buffer.
// Assumes the constants header is on the include path.
`include "sgmii_rx_elastic_buffer_cfg.svh"
package sgmii_rx_elastic_buffer_pkg;
	typedef enum logic [1:0] {RD_NORMAL, RD_INS_K, RD_INS_D} rd_state_t;
	typedef logic [9:0] eb_word_t;
endpackage : sgmii_rx_elastic_buffer_pkg

// ### test_sgmii_rx_elastic_buffer.sv
// Testbench of the receive elastic buffer.
// Assumes the buffer design and the link model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "sgmii_rx_elastic_buffer_cfg.svh"
module test_sgmii_rx_elastic_buffer;
	import sgmii_rx_elastic_buffer_pkg::*;
	logic REF_CLK = 0, RST = 1, REC_CLK = 0, OUT_READY = 1, go = 0;
	logic [15:0] len = 16'h0000;
	logic [7:0] rep = 8'h01;
	wire logic busy, link_k, link_err, bypass, out_k, out_err, out_valid, ovf, unf;
	wire logic [7:0] link_data, out_data;
	logic [7:0] got_q[$];
	logic prev_k = 0;
	int num_errors = 0, checked = 0, cycles = 0, uf_cnt = 0, of_cnt = 0;
	always #2 REF_CLK = !REF_CLK;
	initial #1 forever #3 REC_CLK = !REC_CLK;
	sgmii_link_model u_sgmii_link_model (.rec_clk(REC_CLK), .go(go), .len(len), .rep(rep), .busy(busy),
		.data(link_data), .is_k(link_k), .err(link_err));
	sgmii_rx_elastic_buffer u_sgmii_rx_elastic_buffer (.REF_CLK(REF_CLK), .RST(RST), .REC_CLK(REC_CLK),
		.LINK_DATA(link_data), .LINK_IS_K(link_k), .LINK_ERR(link_err), .LOCAL_DATA(8'h00),
		.LOCAL_IS_K(1'b0), .LOCAL_ERR(1'b0), .XCVR_BUF_BYPASS(bypass), .OUT_DATA(out_data),
		.OUT_IS_K(out_k), .OUT_ERR(out_err), .OUT_VALID(out_valid), .OUT_READY(OUT_READY),
		.BUF_OVERFLOW(ovf), .BUF_UNDERFLOW(unf));
	////////////////////////////////////////////////////////////////////////////////
	task check_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit
	task check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte
	task stop_test;
		$display("Counts: %0d checks, %0d errors", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// Accepted words: idle pairs are checked, data is collected.
	always @(negedge REF_CLK) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			stop_test();
		end
		uf_cnt += (unf === 1'b1);
		of_cnt += (ovf === 1'b1);
		if (out_valid === 1'b1 && OUT_READY === 1'b1) begin
			if (out_k === 1'b1)
				prev_k = 1'b1;
			else if (prev_k) begin
				prev_k = 1'b0;
				check_bit("idle pair", 1'b1, out_data == `EB_IDLE1_D || out_data == `EB_IDLE2_D);
			end else begin
				got_q.push_back(out_data);
				check_bit("error mark", 1'b0, out_err);
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task send_frame(input int n, input int r);
		int k;
		@(negedge REF_CLK);
		len = 16'(n);
		rep = 8'(r);
		go = 1'b1;
		for (k = 0; k < 100 && busy !== 1'b1; k++)
			@(negedge REF_CLK);
		go = 1'b0;
		for (k = 0; k < 2000 && busy !== 1'b0; k++)
			@(negedge REF_CLK);
	endtask : send_frame
	task test_pass(input int n, input int r);
		got_q.delete();
		uf_cnt = 0;
		send_frame(n, r);
		repeat (150) @(negedge REF_CLK);
		check_bit("word count", 1'b1, got_q.size() == n);
		for (int i = 0; i < n && i < got_q.size(); i++)
			check_byte("data", 8'(i / r), got_q[i]);
		check_bit("no underflow", 1'b1, uf_cnt == 0);
		$display("Test pass-through rep %0d done", r);
	endtask : test_pass
	task test_underflow;
		uf_cnt = 0;
		send_frame(400, 1);
		repeat (200) @(negedge REF_CLK);
		check_bit("underflow", 1'b1, uf_cnt > 0);
		$display("Test underflow done");
	endtask : test_underflow
	task test_overflow;
		@(negedge REF_CLK);
		OUT_READY = 1'b0;
		of_cnt = 0;
		repeat (600) @(negedge REF_CLK);
		check_bit("idles deleted", 1'b1, of_cnt == 0);
		send_frame(200, 1);
		repeat (50) @(negedge REF_CLK);
		check_bit("overflow", 1'b1, of_cnt > 0);
		$display("Test overflow done");
	endtask : test_overflow
	initial begin
		repeat (6) @(negedge REF_CLK);
		check_bit("bypass", 1'b1, bypass);
		check_bit("valid in reset", 1'b0, out_valid);
		repeat (6) @(negedge REF_CLK);
		RST = 1'b0;
		repeat (300) @(negedge REF_CLK);
		test_pass(60, 1);
		test_pass(80, `EB_REPEAT_100M);
		test_pass(100, `EB_REPEAT_10M);
		test_underflow();
		repeat (300) @(negedge REF_CLK);
		test_overflow();
		stop_test();
	end
endmodule : test_sgmii_rx_elastic_buffer
`default_nettype wire
